// >>> common/mdic_pkg.sv
// Shared constants and types for the gate-driver configuration loader.
// Assumes strap pins arrive as level codes from the analog strap comparators.
package mdic_pkg;

    localparam int MDIC_FRAME_BITS = 16;
    localparam int MDIC_ADDR_BITS = 4;
    localparam int MDIC_DATA_BITS = 11;
    localparam int MDIC_WR_BIT = 15;
    localparam int MDIC_ADDR_LSB = 11;

    // Layout of the synchronised pin vector; bit 0 of each shared pin group is its logic level
    localparam int MDIC_PIN_W = 11;
    localparam int PIN_VDS_LSB = 0;
    localparam int PIN_GAIN_LSB = 2;
    localparam int PIN_IDRV_LSB = 4;
    localparam int PIN_MODE_LSB = 6;
    localparam int PIN_IFSEL_LSB = 8;

    // Interface-select strap level codes
    localparam logic [2:0] IFSEL_GND = 3'h0;
    localparam logic [2:0] IFSEL_60K = 3'h1;
    localparam logic [2:0] IFSEL_120K = 3'h2;
    localparam logic [2:0] IFSEL_BEMF_MIN = 3'h3;
    localparam logic [2:0] IFSEL_VCC = 3'h7;

    // Register addresses and fields
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DRV = 4'h1;
    localparam logic [3:0] ADDR_STAT = 4'h2;
    localparam logic [10:0] CTRL_RESET = 11'h000;
    localparam logic [10:0] DRV_RESET = 11'h000;
    localparam int CTRL_BEMF_BIT = 0;
    localparam int CTRL_CSMODE_BIT = 1;
    localparam int CTRL_SH_BIT = 2;
    localparam int CTRL_PAIR_LSB = 3;
    localparam int CTRL_BGAIN_LSB = 5;
    localparam int CTRL_CGAIN_LSB = 7;
    localparam int DRV_IDRV_LSB = 0;
    localparam int DRV_VDS_LSB = 2;
    localparam int DRV_DT_LSB = 4;
    localparam int DRV_PWM_BIT = 7;

    // Sample-and-hold phase masks, never more than two phases at once
    localparam logic [1:0] PAIR_C_ONLY = 2'h3;
    localparam logic [2:0] SH_NONE = 3'h0;
    localparam logic [2:0] SH_AB = 3'h3;
    localparam logic [2:0] SH_BC = 3'h6;
    localparam logic [2:0] SH_CA = 3'h5;
    localparam logic [2:0] SH_C = 3'h4;

    // Dead time in ns
    localparam logic [9:0] DT_GND_NS = 10'h064;
    localparam logic [9:0] DT_250_NS = 10'h0fa;
    localparam logic [9:0] DT_450_NS = 10'h1c2;
    localparam logic [9:0] DT_BASE_NS = 10'h064;
    localparam logic [9:0] DT_STEP_NS = 10'h032;

    localparam logic [2:0] SETTLE_CYCLES = 3'h4;

    typedef enum logic [1:0] {
        MDIC_WAIT = 2'b00,
        MDIC_SERIAL = 2'b01,
        MDIC_STRAP = 2'b10
    } mdic_mode_e;

    typedef enum logic [3:0] {
        MDIC_SENSE_NONE = 4'h0,
        MDIC_SENSE_1 = 4'h1,
        MDIC_SENSE_2 = 4'h2,
        MDIC_SENSE_3 = 4'h3,
        MDIC_SENSE_4 = 4'h4,
        MDIC_SENSE_5 = 4'h5,
        MDIC_SENSE_6 = 4'h6,
        MDIC_SENSE_7 = 4'h7,
        MDIC_SENSE_8 = 4'h8,
        MDIC_SENSE_9 = 4'h9
    } mdic_sense_e;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } mdic_spi_pins_s;

    typedef struct packed {
        logic serial;
        logic pwm_mode;
        mdic_sense_e sense_cfg;
        logic back_emf_on;
        logic cs_mode;
        logic [2:0] sh_mask;
        logic amps_continuous;
        logic phase_c_bemf;
        logic [1:0] bemf_gain;
        logic [1:0] cs_gain;
        logic [1:0] idrv;
        logic [1:0] vds_th;
        logic [9:0] dead_time_ns;
    } mdic_settings_s;

    function automatic logic [9:0] mdic_dt_ns(input logic [2:0] code);
        return DT_BASE_NS + DT_STEP_NS * {7'h00, code};
    endfunction : mdic_dt_ns

endpackage : mdic_pkg

// >>> hdl/mdic_serial_slave.sv
// Serial slave shift engine, clock phase 0: sample on rising, shift out on falling.
// Assumes all pin inputs are already synchronised to clock_in.
`timescale 1ns/1ps
`default_nettype none
module mdic_serial_slave import mdic_pkg::*; #(
    parameter int FRAME_BITS = MDIC_FRAME_BITS
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic enable_in,
    input wire mdic_spi_pins_s pins_in,
    input wire logic [FRAME_BITS-1:0] tx_word_in,
    output logic frame_valid_out,
    output logic [FRAME_BITS-1:0] rx_word_out,
    output logic sdo_out,
    output logic sdo_oe_out
);
    localparam int CW = $clog2(FRAME_BITS + 2);

    if (FRAME_BITS < 2) begin : g_check
        $error("mdic_serial_slave: FRAME_BITS too small");
    end

    typedef struct packed {
        logic sclk_q;
        logic cs_n_q;
        logic [CW-1:0] count;
        logic [FRAME_BITS-1:0] rx_sh;
        logic [FRAME_BITS-1:0] tx_sh;
        logic sdo;
        logic oe;
        logic valid;
        logic [FRAME_BITS-1:0] rx;
    } mdic_slave_s;

    mdic_slave_s s;
    mdic_slave_s next_s;

    always_comb begin
        next_s = s;
        next_s.valid = 1'b0;
        next_s.sclk_q = pins_in.sclk;
        next_s.cs_n_q = enable_in ? pins_in.cs_n : 1'b1;
        if (!enable_in) begin
            next_s.count = '0;
            next_s.oe = 1'b0;
            next_s.sdo = 1'b0;
        end else if (pins_in.cs_n) begin
            next_s.oe = 1'b0;
            // Only an exact word is accepted; short or long frames vanish
            if (!s.cs_n_q && s.count == CW'(FRAME_BITS)) begin
                next_s.valid = 1'b1;
                next_s.rx = s.rx_sh;
            end
        end else if (s.cs_n_q) begin
            next_s.count = '0;
            next_s.tx_sh = tx_word_in;
            next_s.sdo = tx_word_in[FRAME_BITS-1];
            next_s.oe = 1'b1;
        end else if (pins_in.sclk && !s.sclk_q) begin
            // Clock idle between two byte transfers keeps the count running
            next_s.rx_sh = {s.rx_sh[FRAME_BITS-2:0], pins_in.sdi};
            if (s.count <= CW'(FRAME_BITS)) begin
                next_s.count = s.count + 1'b1;
            end
        end else if (!pins_in.sclk && s.sclk_q) begin
            next_s.tx_sh = {s.tx_sh[FRAME_BITS-2:0], 1'b0};
            next_s.sdo = s.tx_sh[FRAME_BITS-2];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            s <= '0;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign frame_valid_out = s.valid;
    assign rx_word_out = s.rx;
    assign sdo_out = s.sdo;
    assign sdo_oe_out = s.oe;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    frame_length_a: assert property ($rose(s.valid) |-> $past(s.count) == CW'(FRAME_BITS))
        else $error("frame accepted with wrong bit count");
    sdo_release_a: assert property (ce_in && pins_in.cs_n |=> !s.oe)
        else $error("serial out driven while deselected");
    frame_seen_c: cover property (s.valid);

endmodule : mdic_serial_slave
`default_nettype wire

// >>> hdl/mdic_config.sv
// Configuration loader: picks serial or strap setup and decodes driver settings.
// Assumes strap inputs are comparator level codes, asynchronous to clock_in.
// How it works
// - Select strap at supply level gives serial mode, settings from serial registers.
// - Select strap at ground or through resistor gives strap mode.
// - Four-wire serial port is slave only; never drives the clock.
// - In serial mode the shared strap pins become data, clock and select.
// - Every serial frame carries exactly one sixteen-bit word.
// - In strap mode the select strap sets dead time and back-EMF enable.
// - Straps set source current, input mode, sensing, gain and overcurrent threshold.
// - Nine sensing configurations in serial mode, four in strap mode.
// - Configuration 6 senses three currents continuously, no hold, back-EMF off.
// - All three sensing bits at zero select configuration 6.
// - Serial power-up clears the sensing bits, starting in configuration 6.
// - In strap mode 60.4k gives 250 ns, 120k gives 450 ns.
// - Mode strap high selects PWM input mode, low selects separate high/low mode.
// - Sample-and-hold may trigger on at most two phases together.
// - Back-EMF path has four gains and leaves on the phase C output.
`timescale 1ns/1ps
`default_nettype none
module mdic_config import mdic_pkg::*; #(
    parameter int FRAME_BITS = MDIC_FRAME_BITS
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic [2:0] interface_select_strap_in,
    input wire logic [1:0] source_current_strap_or_serial_in_in,
    input wire logic [1:0] input_mode_strap_or_serial_out_in,
    input wire logic [1:0] gain_strap_or_serial_clock_in,
    input wire logic [1:0] threshold_strap_or_chip_select_in,
    output logic input_mode_strap_or_serial_out_out,
    output logic input_mode_strap_or_serial_out_oe_out,
    output logic config_valid_out,
    output mdic_settings_s settings_out
);
    if (FRAME_BITS != MDIC_FRAME_BITS) begin : g_check
        $error("mdic_config: register layout needs a 16-bit frame");
    end

    typedef struct packed {
        logic [MDIC_PIN_W-1:0] sync1;
        logic [MDIC_PIN_W-1:0] sync2;
        mdic_mode_e mode;
        logic [2:0] settle;
        logic [2:0] strap_ifsel;
        logic [1:0] strap_mode;
        logic [1:0] strap_idrv;
        logic [1:0] strap_gain;
        logic [1:0] strap_vds;
        logic [MDIC_DATA_BITS-1:0] ctrl;
        logic [MDIC_DATA_BITS-1:0] drv;
        logic [FRAME_BITS-1:0] tx_word;
        logic valid;
        mdic_settings_s set;
    } mdic_state_s;

    mdic_state_s s;
    mdic_state_s next_s;
    mdic_spi_pins_s spi_pins;
    logic frame_valid;
    logic [FRAME_BITS-1:0] rx_word;

    // Shared pins reach the serial engine only from the second sync stage
    assign spi_pins.cs_n = s.sync2[PIN_VDS_LSB];
    assign spi_pins.sclk = s.sync2[PIN_GAIN_LSB];
    assign spi_pins.sdi = s.sync2[PIN_IDRV_LSB];

    mdic_serial_slave #(
        .FRAME_BITS(FRAME_BITS)
    ) u_slave (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .enable_in(s.mode == MDIC_SERIAL),
        .pins_in(spi_pins),
        .tx_word_in(s.tx_word),
        .frame_valid_out(frame_valid),
        .rx_word_out(rx_word),
        .sdo_out(input_mode_strap_or_serial_out_out),
        .sdo_oe_out(input_mode_strap_or_serial_out_oe_out)
    );

    always_comb begin
        logic [3:0] addr;
        logic [MDIC_DATA_BITS-1:0] rdata;
        logic [1:0] pair;
        logic rdson;
        addr = rx_word[MDIC_ADDR_LSB +: MDIC_ADDR_BITS];
        rdata = '0;
        pair = s.ctrl[CTRL_PAIR_LSB +: 2];
        rdson = s.strap_mode[1] ^ s.strap_mode[0];
        next_s = s;
        next_s.sync1 = {interface_select_strap_in, input_mode_strap_or_serial_out_in,
                        source_current_strap_or_serial_in_in, gain_strap_or_serial_clock_in,
                        threshold_strap_or_chip_select_in};
        next_s.sync2 = s.sync1;

        case (addr)
            ADDR_CTRL: rdata = s.ctrl;
            ADDR_DRV: rdata = s.drv;
            ADDR_STAT: rdata = {1'b0, s.set.serial, s.set.pwm_mode, s.set.sh_mask,
                                s.set.back_emf_on, s.set.sense_cfg};
            default: rdata = '0;
        endcase

        case (s.mode)
            MDIC_WAIT: begin
                // Wait until both sync stages hold real pin levels, then latch once
                if (s.settle == SETTLE_CYCLES) begin
                    next_s.strap_ifsel = s.sync2[PIN_IFSEL_LSB +: 3];
                    next_s.strap_mode = s.sync2[PIN_MODE_LSB +: 2];
                    next_s.strap_idrv = s.sync2[PIN_IDRV_LSB +: 2];
                    next_s.strap_gain = s.sync2[PIN_GAIN_LSB +: 2];
                    next_s.strap_vds = s.sync2[PIN_VDS_LSB +: 2];
                    if (s.sync2[PIN_IFSEL_LSB +: 3] == IFSEL_VCC) begin
                        next_s.mode = MDIC_SERIAL;
                    end else begin
                        next_s.mode = MDIC_STRAP;
                    end
                end else begin
                    next_s.settle = s.settle + 1'b1;
                end
            end
            MDIC_SERIAL: begin
                if (frame_valid) begin
                    if (!rx_word[MDIC_WR_BIT]) begin
                        if (addr == ADDR_CTRL) begin
                            next_s.ctrl = rx_word[MDIC_DATA_BITS-1:0];
                        end else if (addr == ADDR_DRV) begin
                            next_s.drv = rx_word[MDIC_DATA_BITS-1:0];
                        end
                    end
                    // Reply goes out in the following frame
                    next_s.tx_word = {1'b0, addr, rdata};
                end
            end
            MDIC_STRAP: begin
                next_s.mode = MDIC_STRAP;
            end
            default: begin
                next_s.mode = MDIC_WAIT;
            end
        endcase

        next_s.valid = (s.mode != MDIC_WAIT);
        next_s.set = '0;
        if (s.mode == MDIC_SERIAL) begin
            next_s.set.serial = 1'b1;
            next_s.set.back_emf_on = s.ctrl[CTRL_BEMF_BIT];
            next_s.set.cs_mode = s.ctrl[CTRL_CSMODE_BIT];
            next_s.set.bemf_gain = s.ctrl[CTRL_BGAIN_LSB +: 2];
            next_s.set.cs_gain = s.ctrl[CTRL_CGAIN_LSB +: 2];
            next_s.set.idrv = s.drv[DRV_IDRV_LSB +: 2];
            next_s.set.vds_th = s.drv[DRV_VDS_LSB +: 2];
            next_s.set.dead_time_ns = mdic_dt_ns(s.drv[DRV_DT_LSB +: 3]);
            next_s.set.pwm_mode = s.drv[DRV_PWM_BIT];
            if (s.ctrl[CTRL_SH_BIT]) begin
                case (pair)
                    2'h0: next_s.set.sh_mask = SH_AB;
                    2'h1: next_s.set.sh_mask = SH_BC;
                    2'h2: next_s.set.sh_mask = SH_CA;
                    default: next_s.set.sh_mask = SH_C;
                endcase
            end
            case ({s.ctrl[CTRL_BEMF_BIT], s.ctrl[CTRL_CSMODE_BIT], s.ctrl[CTRL_SH_BIT]})
                3'b000: next_s.set.sense_cfg = MDIC_SENSE_6;
                3'b001: next_s.set.sense_cfg = (pair == PAIR_C_ONLY) ? MDIC_SENSE_5
                                                                    : MDIC_SENSE_7;
                3'b010: next_s.set.sense_cfg = MDIC_SENSE_8;
                3'b011: next_s.set.sense_cfg = MDIC_SENSE_9;
                3'b100: next_s.set.sense_cfg = MDIC_SENSE_1;
                3'b101: next_s.set.sense_cfg = MDIC_SENSE_2;
                3'b110: next_s.set.sense_cfg = MDIC_SENSE_3;
                default: next_s.set.sense_cfg = MDIC_SENSE_4;
            endcase
        end else if (s.mode == MDIC_STRAP) begin
            next_s.set.back_emf_on = (s.strap_ifsel >= IFSEL_BEMF_MIN);
            next_s.set.cs_mode = rdson;
            next_s.set.pwm_mode = s.strap_mode[1];
            next_s.set.idrv = s.strap_idrv;
            next_s.set.cs_gain = s.strap_gain;
            next_s.set.vds_th = s.strap_vds;
            if (s.strap_ifsel == IFSEL_GND) begin
                next_s.set.dead_time_ns = DT_GND_NS;
            end else begin
                next_s.set.dead_time_ns = s.strap_ifsel[0] ? DT_250_NS : DT_450_NS;
            end
            // Strap mode has no hold control, so only four combinations exist
            if (s.strap_ifsel >= IFSEL_BEMF_MIN) begin
                next_s.set.sense_cfg = rdson ? MDIC_SENSE_3 : MDIC_SENSE_1;
            end else begin
                next_s.set.sense_cfg = rdson ? MDIC_SENSE_8 : MDIC_SENSE_6;
            end
        end
        // Without any hold and with back-EMF off the amplifiers stream straight to their pins
        next_s.set.amps_continuous = (next_s.set.sh_mask == SH_NONE) && !next_s.set.back_emf_on;
        next_s.set.phase_c_bemf = next_s.set.back_emf_on;
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            s <= '0;
            s.ctrl <= CTRL_RESET;
            s.drv <= DRV_RESET;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign config_valid_out = s.valid;
    assign settings_out = s.set;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    serial_select_a: assert property (s.valid |->
                                      s.set.serial == (s.strap_ifsel == IFSEL_VCC))
        else $error("serial mode does not follow select strap");
    strap_select_a: assert property (s.mode == MDIC_STRAP |-> s.strap_ifsel != IFSEL_VCC)
        else $error("strap mode entered with select at supply");
    pins_quiet_a: assert property (!s.set.serial |->
                                   !input_mode_strap_or_serial_out_oe_out)
        else $error("serial out driven outside serial mode");
    cfg_zero_a: assert property (ce_in && s.mode == MDIC_SERIAL && s.ctrl[2:0] == 3'h0
                                 |=> s.set.sense_cfg == MDIC_SENSE_6)
        else $error("zero sensing bits did not give configuration 6");
    cfg6_shape_a: assert property (s.set.sense_cfg == MDIC_SENSE_6 |->
                                   s.set.amps_continuous && !s.set.back_emf_on
                                   && s.set.sh_mask == SH_NONE)
        else $error("configuration 6 not continuous three-phase");
    powerup_cfg_a: assert property ($rose(s.valid) |-> s.ctrl == CTRL_RESET)
        else $error("sensing bits not cleared at power-up");
    dead_time_a: assert property (ce_in && s.mode == MDIC_STRAP && s.strap_ifsel == IFSEL_60K
                                  |=> s.set.dead_time_ns == DT_250_NS)
        else $error("60.4k strap did not give 250 ns");
    input_mode_a: assert property (s.valid && !s.set.serial |->
                                   s.set.pwm_mode == s.strap_mode[1])
        else $error("input mode does not follow mode strap");
    sh_limit_a: assert property ($countones(s.set.sh_mask) <= 2)
        else $error("hold armed on three phases");
    strap_four_a: assert property (s.valid && !s.set.serial |->
                                   s.set.sense_cfg inside {MDIC_SENSE_1, MDIC_SENSE_3,
                                                           MDIC_SENSE_6, MDIC_SENSE_8})
        else $error("strap mode produced an unreachable configuration");
    strap_hold_a: assert property (s.valid && $past(s.valid) |->
                                   $stable(s.strap_ifsel) && $stable(s.strap_mode))
        else $error("latched straps changed after power-up");
    bemf_pin_a: assert property (s.valid && s.strap_ifsel >= IFSEL_BEMF_MIN && !s.set.serial
                                 |-> s.set.phase_c_bemf)
        else $error("back-emf strap did not route phase C output");

    serial_write_c: cover property (frame_valid && !rx_word[MDIC_WR_BIT]);
    strap_mode_c: cover property (s.valid && !s.set.serial);
    cfg6_serial_c: cover property (s.set.serial && s.set.sense_cfg == MDIC_SENSE_6);

endmodule : mdic_config
`default_nettype wire

// >>> testbench/mdic_spi_master.sv
// Serial master model of the motor controller: 16-bit frames, clock phase 0, MSB first.
// Assumes clock_in is the bench clock; the link clock is paced from it at 160 ns a period.
`timescale 1ns/1ps
`default_nettype none
module mdic_spi_master import mdic_pkg::*; (
    input wire logic clock_in,
    input wire logic sdo_in,
    output mdic_spi_pins_s pins_out
);
    initial pins_out = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};

    // Link clock stands low outside frames; the master alone makes it
    task automatic xfer(input logic [15:0] word, input int nbits, input bit split,
                        output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clock_in) pins_out.cs_n <= 1'b0;
        repeat (8) @(posedge clock_in);
        for (int i = 0; i < nbits; i++) begin
            pins_out.sdi <= word[15-i];
            // Byte-wide controller: idle gap, no clock edges, select held low
            if (split && i == 8) repeat (24) @(posedge clock_in);
            repeat (8) @(posedge clock_in);
            pins_out.sclk <= 1'b1;
            rx = {rx[14:0], sdo_in};
            repeat (8) @(posedge clock_in);
            pins_out.sclk <= 1'b0;
        end
        repeat (8) @(posedge clock_in);
        pins_out.cs_n <= 1'b1;
        // Released data line shows the inverse so a stale bit is never taken as valid
        pins_out.sdi <= ~pins_out.sdi;
        repeat (8) @(posedge clock_in);
    endtask : xfer
endmodule : mdic_spi_master
`default_nettype wire

// >>> testbench/motor_driver_interface_config_tb_top.sv
// Self-checking bench for the configuration loader: serial and strap power-ups.
// Assumes the master model owns the shared pins whenever the select strap sits at supply.
`timescale 1ns/1ps
`default_nettype none
module motor_driver_interface_config_tb_top import mdic_pkg::*; ;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [2:0] ifsel = IFSEL_VCC;
    logic [1:0] idrv_s = 2'h2;
    logic [1:0] mode_s = 2'h3;
    logic [1:0] gain_s = 2'h1;
    logic [1:0] vds_s = 2'h3;
    logic sdo, sdo_oe, valid;
    mdic_spi_pins_s pins;
    mdic_settings_s set;
    logic [15:0] rx;
    int bad_count = 0;
    int checks = 0;
    // Strap cases: select code, mode code, sensing config, pwm, dead time
    logic [19:0] stab [5] = '{{3'h1, 2'h3, 4'h6, 1'b1, 10'h0fa}, {3'h2, 2'h0, 4'h6, 1'b0, 10'h1c2},
        {3'h3, 2'h2, 4'h3, 1'b1, 10'h0fa}, {3'h0, 2'h1, 4'h8, 1'b0, 10'h064},
        {3'h4, 2'h3, 4'h1, 1'b1, 10'h1c2}};
    logic [3:0] cfg_tab [8] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'h1, 4'h2, 4'h3, 4'h4};
    wire logic serial_pins = (ifsel == IFSEL_VCC);
    // Pulled up while nobody drives the data-out line
    wire logic sdo_line = sdo_oe ? sdo : 1'b1;

    always #5 clock_in = ~clock_in;

    mdic_config uut (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .ce_in(1'b1),
        .interface_select_strap_in(ifsel),
        .source_current_strap_or_serial_in_in(serial_pins ? {idrv_s[1], pins.sdi} : idrv_s),
        .input_mode_strap_or_serial_out_in(serial_pins ? {mode_s[1], sdo_line} : mode_s),
        .gain_strap_or_serial_clock_in(serial_pins ? {gain_s[1], pins.sclk} : gain_s),
        .threshold_strap_or_chip_select_in(serial_pins ? {vds_s[1], pins.cs_n} : vds_s),
        .input_mode_strap_or_serial_out_out(sdo),
        .input_mode_strap_or_serial_out_oe_out(sdo_oe),
        .config_valid_out(valid),
        .settings_out(set)
    );

    mdic_spi_master mst (.clock_in(clock_in), .sdo_in(sdo_line), .pins_out(pins));

    task automatic end_sim;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic power_up(input logic [2:0] sel, input logic [1:0] mode);
        @(posedge clock_in);
        reset_n_in <= 1'b0;
        ifsel <= sel;
        mode_s <= mode;
        repeat (3) @(posedge clock_in);
        reset_n_in <= 1'b1;
        for (int n = 0; n < 20 && valid !== 1'b1; n++) @(negedge clock_in);
        if (valid !== 1'b1) begin
            bad_count++;
            end_sim();
        end
    endtask : power_up

    task automatic frame(input logic [15:0] w, input int n, input bit sp);
        mst.xfer(w, n, sp, rx);
        @(negedge clock_in);
    endtask : frame

    initial begin
        power_up(IFSEL_VCC, 2'h3);
        check(16'(set.serial), 16'h0001);
        check(16'(set.sense_cfg), 16'(MDIC_SENSE_6));
        check(16'(set.amps_continuous), 16'h0001);
        check(16'({set.back_emf_on, sdo_oe}), 16'h0000);
        for (logic [3:0] k = 0; k < 8; k++) begin
            frame({1'b0, ADDR_CTRL, 2'h0, 2'h1, 2'h2, 2'h0, k[0], k[1], k[2]}, 16, 1'b0);
            check(16'(set.sense_cfg), 16'(cfg_tab[k]));
            check(16'({set.back_emf_on, set.cs_mode, set.phase_c_bemf}),
                  16'({k[2], k[1], k[2]}));
            check(16'(set.sh_mask), 16'(k[0] ? SH_AB : SH_NONE));
            check(16'(set.amps_continuous), 16'(!(k[2] | k[0])));
        end
        check(16'({set.bemf_gain, set.cs_gain}), 16'h0009);
        frame({1'b0, ADDR_CTRL, 11'h0dc}, 16, 1'b0);
        check(16'(set.sense_cfg), 16'(MDIC_SENSE_5));
        check(16'(set.sh_mask), 16'(SH_C));
        frame({1'b0, ADDR_DRV, 11'h0b6}, 16, 1'b0);
        check(16'({set.pwm_mode, set.idrv, set.vds_th}), 16'h0019);
        check(16'(set.dead_time_ns), 16'(DT_250_NS));
        frame(16'h8000, 16, 1'b0);
        check(rx, {1'b0, ADDR_DRV, 11'h000});
        frame({1'b0, ADDR_CTRL, 11'h000}, 16, 1'b1);
        check(rx, {1'b0, ADDR_CTRL, 11'h0dc});
        check(16'(set.sense_cfg), 16'(MDIC_SENSE_6));
        frame({1'b0, ADDR_CTRL, 11'h001}, 15, 1'b0);
        check(16'({set.sense_cfg, set.back_emf_on}), 16'({MDIC_SENSE_6, 1'b0}));
        frame(16'h8000, 16, 1'b0);
        check(rx, {1'b0, ADDR_CTRL, 11'h0dc});
        // Status read: its reply comes back in the frame after
        frame({1'b1, ADDR_STAT, 11'h000}, 16, 1'b0);
        check(rx, {1'b0, ADDR_CTRL, 11'h000});
        frame(16'h8000, 16, 1'b0);
        check(rx, {1'b0, ADDR_STAT, 1'b0, 1'b1, 1'b1, SH_NONE, 1'b0, 4'(MDIC_SENSE_6)});
        $display("test serial done");
        for (int t = 0; t < 5; t++) begin
            power_up(stab[t][19:17], stab[t][16:15]);
            check(16'({set.serial, sdo_oe}), 16'h0000);
            check(16'(set.sense_cfg), 16'(stab[t][14:11]));
            check(16'(set.pwm_mode), 16'(stab[t][10]));
            check(16'(set.dead_time_ns), 16'(stab[t][9:0]));
            check(16'(set.back_emf_on), 16'(stab[t][19:17] >= IFSEL_BEMF_MIN));
            check(16'(set.cs_mode), 16'(stab[t][16] ^ stab[t][15]));
            // Gate inputs the controller must drive: three in PWM mode, six in high/low mode
            check(16'(set.pwm_mode ? 3 : 6), 16'(stab[t][10] ? 3 : 6));
            check(16'({set.idrv, set.cs_gain, set.vds_th}), 16'({idrv_s, gain_s, vds_s}));
            // Straps moved after the latch, select pulled to supply last
            @(posedge clock_in);
            ifsel <= (t == 4) ? IFSEL_VCC : IFSEL_GND;
            mode_s <= ~stab[t][16:15];
            repeat (10) @(negedge clock_in);
            check(16'({set.serial, set.sense_cfg, set.pwm_mode}),
                  16'({1'b0, stab[t][14:11], stab[t][10]}));
            check(16'(set.dead_time_ns), 16'(stab[t][9:0]));
        end
        $display("test strap done");
        end_sim();
    end
endmodule : motor_driver_interface_config_tb_top
`default_nettype wire
